// ### uesc_regs.vh
`ifndef UESC_REGS_VH
`define UESC_REGS_VH
// Register indices; byte address is four times the index.
`define UESC_IDX_ERR_EN 4'h0
`define UESC_IDX_STATUS 4'h1
`define UESC_IDX_CONTROL 4'h2
`define UESC_IDX_ERR_FLAGS 4'h3
`define UESC_IDX_IRQ_CTRL 4'h4
// Control bit positions.
`define UESC_CON_J 7
`define UESC_CON_SE0 6
`define UESC_CON_HOLD 5
`define UESC_CON_BUSRST 4
`define UESC_CON_HOST 3
`define UESC_CON_RESUME 2
`define UESC_CON_PPCLR 1
`define UESC_CON_EN 0
// Interrupt control bits: bit 0 transfer done flag, bit 1 general error enable.
`define UESC_IRQ_TDONE 0
`define UESC_IRQ_GERR 1
// Reset values.
`define UESC_RST_BYTE 8'h00
// Status FIFO depth.
`define UESC_FIFO_DEPTH 4
`define UESC_FIFO_PW 2
// Frame start period: 1 ms at 200 MHz is 200000 cycles.
`define UESC_SOF_CYCLES 18'h30D40
`endif

// ### uesc_stat_fifo.v
`timescale 1ns/100ps
`include "uesc_regs.vh"
module uesc_stat_fifo (
	// Clock and reset
	input wire core_clk,
	input wire reset_n,
	// Push side
	input wire push,
	input wire [5:0] push_data,
	// Pop side
	input wire pop,
	output wire [5:0] head_data,
	output wire not_empty,
	output wire full
);
	reg [5:0] mem_r [0:`UESC_FIFO_DEPTH-1];
	reg [`UESC_FIFO_PW-1:0] wp_r;
	reg [`UESC_FIFO_PW-1:0] rp_r;
	reg [`UESC_FIFO_PW:0] cnt_r;
	wire do_push;
	wire do_pop;
	integer i;

	assign full = (cnt_r == `UESC_FIFO_DEPTH);
	assign not_empty = (cnt_r != 0);
	assign do_pop = pop && not_empty;
	assign do_push = push && (!full || do_pop);
	assign head_data = mem_r[rp_r];

	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			wp_r <= {`UESC_FIFO_PW{1'b0}};
			rp_r <= {`UESC_FIFO_PW{1'b0}};
			cnt_r <= {(`UESC_FIFO_PW + 1){1'b0}};
			for (i = 0; i < `UESC_FIFO_DEPTH; i = i + 1) begin
				mem_r[i] <= 6'h00;
			end
		end else begin
			if (do_push) begin
				mem_r[wp_r] <= push_data;
				wp_r <= wp_r + 1'b1;
			end
			if (do_pop) begin
				rp_r <= rp_r + 1'b1;
			end
			if (do_push && !do_pop) begin
				cnt_r <= cnt_r + 1'b1;
			end else if (do_pop && !do_push) begin
				cnt_r <= cnt_r - 1'b1;
			end
		end
	end
endmodule

// ### uesc_sof_timer.v
`timescale 1ns/100ps
`include "uesc_regs.vh"
module uesc_sof_timer #(
	parameter [17:0] PERIOD = `UESC_SOF_CYCLES
) (
	// Clock and reset
	input wire core_clk,
	input wire reset_n,
	// Control
	input wire run,
	// Tick out
	output reg tick
);
	reg [17:0] cnt_r;

	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_r <= 18'h00000;
			tick <= 1'b0;
		end else if (!run) begin
			cnt_r <= 18'h00000;
			tick <= 1'b0;
		end else if (cnt_r == PERIOD - 18'h00001) begin
			cnt_r <= 18'h00000;
			tick <= 1'b1;
		end else begin
			cnt_r <= cnt_r + 18'h00001;
			tick <= 1'b0;
		end
	end
endmodule

// ### uesc_ctrl.v
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/100ps
`include "uesc_regs.vh"
module uesc_ctrl #(
	parameter [17:0] SOF_CYCLES = `UESC_SOF_CYCLES
) (
	// Clock and reset
	input wire core_clk,
	input wire reset_n,
	// Register port
	input wire [3:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata,
	// Line state pins
	input wire line_dp,
	input wire line_dm,
	// Protocol engine events
	input wire [7:0] err_events,
	input wire xfer_done,
	input wire [3:0] xfer_endpoint,
	input wire xfer_tx,
	input wire xfer_odd,
	input wire setup_rx,
	input wire token_start,
	input wire token_end,
	// Engine controls
	output reg module_enable,
	output reg frame_start_auto_enable,
	output reg bus_reset_drive,
	output reg resume_drive,
	output reg ls_eop_append,
	output reg host_logic_reset,
	output reg pingpong_pointer_clear,
	output reg packet_processing_hold,
	output reg frame_start_tick,
	output reg status_fifo_full,
	// Interrupt request
	output reg module_irq_flag
);
	// Enable, control and flag storage.
	reg [7:0] usb_error_irq_enable_r;
	reg [7:0] err_flags_r;
	reg [7:0] err_flags_nxt;
	reg host_role_enable_r;
	reg host_role_enable_nxt;
	reg resume_r;
	reg bus_reset_r;
	reg module_en_r;
	reg pkt_hold_r;
	reg pkt_hold_nxt;
	reg token_in_progress_r;
	reg token_busy_nxt;
	reg transfer_done_flag_r;
	reg transfer_done_flag_nxt;
	reg general_error_enable_r;
	reg [1:0] dp_sync_r;
	reg [1:0] dm_sync_r;
	wire live_j_level;
	wire live_se0;
	wire [5:0] head_data;
	wire fifo_not_empty;
	wire fifo_full;
	wire fifo_pop;
	wire wr_en;
	wire wr_con;
	wire wr_irq;
	wire sof_tick;
	wire [7:0] status_byte;
	wire [7:0] control_byte;
	wire err_req;
	wire resume_end;

	function sel;
		input [3:0] addr;
		input [3:0] idx;
		begin
			sel = (addr == idx);
		end
	endfunction

	// After reset both lines read low, so bit 6 is briefly set.
	// Line pins pass two flip-flops before use.
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			dp_sync_r <= 2'h0;
			dm_sync_r <= 2'h0;
		end else begin
			dp_sync_r <= {dp_sync_r[0], line_dp};
			dm_sync_r <= {dm_sync_r[0], line_dm};
		end
	end

	// Full speed J is D+ high, D- low.
	// A low-speed link idles the other way, so bit 7 then shows K.
	assign live_j_level = dp_sync_r[1] & ~dm_sync_r[1];
	assign live_se0 = ~dp_sync_r[1] & ~dm_sync_r[1];

	// Unmapped indices decode to nothing, so their writes are dropped.
	assign wr_en = reg_wr && sel(reg_addr, `UESC_IDX_ERR_EN);
	assign wr_con = reg_wr && sel(reg_addr, `UESC_IDX_CONTROL);
	assign wr_irq = reg_wr && sel(reg_addr, `UESC_IDX_IRQ_CTRL);

	// Writing 1 to the done flag releases the FIFO head.
	assign fifo_pop = wr_irq && reg_wdata[`UESC_IRQ_TDONE] &&
		transfer_done_flag_r;

	// A completion that finds the queue full and no pop is lost.
	// Software must drain the queue before a fifth transfer arrives while four are queued.
	uesc_stat_fifo u_fifo (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.push(xfer_done),
		.push_data({xfer_endpoint, xfer_tx, xfer_odd}),
		.pop(fifo_pop),
		.head_data(head_data),
		.not_empty(fifo_not_empty),
		.full(fifo_full)
	);

	// The frame timer restarts whenever host role or enable drops.
	uesc_sof_timer #(
		.PERIOD(SOF_CYCLES)
	) u_sof (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.run(module_en_r && host_role_enable_r),
		.tick(sof_tick)
	);

	// Error flags: hardware set wins over software clear.
	always @* begin
		err_flags_nxt = err_flags_r;
		// Writing zero to a flag leaves it as it is.
		if (reg_wr && sel(reg_addr, `UESC_IDX_ERR_FLAGS)) begin
			err_flags_nxt = err_flags_nxt & ~reg_wdata[7:0];
		end
		err_flags_nxt = err_flags_nxt | err_events;
	end

	// Bit 1 event source is chosen upstream by mode; the gate is shared.
	assign err_req = |(err_flags_r & usb_error_irq_enable_r);

	// A control write that drops resume ends the wake-up signal.
	assign resume_end = wr_con && resume_r &&
		!reg_wdata[`UESC_CON_RESUME];

	always @* begin
		host_role_enable_nxt = host_role_enable_r;
		if (wr_con) begin
			host_role_enable_nxt = reg_wdata[`UESC_CON_HOST];
		end
	end

	// Bit 5: packet hold in device mode, token busy in host mode.
	always @* begin
		pkt_hold_nxt = pkt_hold_r;
		if (wr_con && !reg_wdata[`UESC_CON_HOLD]) begin
			pkt_hold_nxt = 1'b0;
		end
		// A SETUP beside a clearing write wins, so no packet slips through.
		if (setup_rx && !host_role_enable_r) begin
			pkt_hold_nxt = 1'b1;
		end
		token_busy_nxt = token_in_progress_r;
		if (token_end) begin
			token_busy_nxt = 1'b0;
		end
		if (token_start && host_role_enable_r) begin
			token_busy_nxt = 1'b1;
		end
		if (host_role_enable_nxt != host_role_enable_r) begin
			token_busy_nxt = 1'b0;
		end
	end

	// A pop drops the done flag for one cycle so its clear is seen; an
	// entry left behind raises it again, and a full queue keeps it up.
	always @* begin
		transfer_done_flag_nxt = fifo_not_empty;
		if (fifo_pop) begin
			transfer_done_flag_nxt = fifo_full;
		end
		if (xfer_done) begin
			transfer_done_flag_nxt = 1'b1;
		end
	end

	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			usb_error_irq_enable_r <= `UESC_RST_BYTE;
			err_flags_r <= `UESC_RST_BYTE;
			host_role_enable_r <= 1'b0;
			resume_r <= 1'b0;
			bus_reset_r <= 1'b0;
			module_en_r <= 1'b0;
			pkt_hold_r <= 1'b0;
			token_in_progress_r <= 1'b0;
			transfer_done_flag_r <= 1'b0;
			general_error_enable_r <= 1'b0;
			pingpong_pointer_clear <= 1'b0;
			host_logic_reset <= 1'b0;
			ls_eop_append <= 1'b0;
		end else begin
			err_flags_r <= err_flags_nxt;
			pkt_hold_r <= pkt_hold_nxt;
			token_in_progress_r <= token_busy_nxt;
			host_role_enable_r <= host_role_enable_nxt;
			// Any toggle of the host bit restarts the host side.
			host_logic_reset <= host_role_enable_nxt != host_role_enable_r;
			if (wr_en) begin
				usb_error_irq_enable_r <= reg_wdata[7:0];
			end
			if (wr_irq) begin
				general_error_enable_r <= reg_wdata[`UESC_IRQ_GERR];
			end
			if (wr_con) begin
				bus_reset_r <= reg_wdata[`UESC_CON_BUSRST];
				resume_r <= reg_wdata[`UESC_CON_RESUME];
				module_en_r <= reg_wdata[`UESC_CON_EN];
			end
			// Pulse on a write of 1; the bit itself never reads back set.
			pingpong_pointer_clear <= wr_con && reg_wdata[`UESC_CON_PPCLR];
			ls_eop_append <= resume_end && host_role_enable_r;
			transfer_done_flag_r <= transfer_done_flag_nxt;
		end
	end

	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			module_enable <= 1'b0;
			frame_start_auto_enable <= 1'b0;
			bus_reset_drive <= 1'b0;
			resume_drive <= 1'b0;
			packet_processing_hold <= 1'b0;
			frame_start_tick <= 1'b0;
			status_fifo_full <= 1'b0;
			module_irq_flag <= 1'b0;
		end else begin
			// Engine controls lag the control bits by one cycle.
			module_enable <= module_en_r && !host_role_enable_r;
			frame_start_auto_enable <= module_en_r && host_role_enable_r;
			bus_reset_drive <= bus_reset_r;
			resume_drive <= resume_r;
			packet_processing_hold <= pkt_hold_r && !host_role_enable_r;
			frame_start_tick <= sof_tick;
			status_fifo_full <= fifo_full;
			// An error needs its own enable and the general enable.
			module_irq_flag <= err_req && general_error_enable_r;
		end
	end

	// Status reads as zero while no entry is valid.
	assign status_byte = transfer_done_flag_r ?
		{head_data, 2'b00} : 8'h00;
	// Bit 5 shows token busy in host mode and packet hold in device mode.
	// Bit 1 only strobes the pointer clear, so it always reads zero.
	assign control_byte = {live_j_level, live_se0,
		host_role_enable_r ? token_in_progress_r : pkt_hold_r,
		bus_reset_r, host_role_enable_r, resume_r, 1'b0, module_en_r};

	// Read data stand for the one cycle after the strobe, zero otherwise.
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata <= 32'h00000000;
		end else if (reg_rd) begin
			case (reg_addr)
			`UESC_IDX_ERR_EN: reg_rdata <= {24'h000000, usb_error_irq_enable_r};
			`UESC_IDX_STATUS: reg_rdata <= {24'h000000, status_byte};
			`UESC_IDX_CONTROL: reg_rdata <= {24'h000000, control_byte};
			`UESC_IDX_ERR_FLAGS: reg_rdata <= {24'h000000, err_flags_r};
			`UESC_IDX_IRQ_CTRL: reg_rdata <= {30'h0,
				general_error_enable_r, transfer_done_flag_r};
			default: reg_rdata <= 32'h00000000;
			endcase
		end else begin
			reg_rdata <= 32'h00000000;
		end
	end
endmodule

// ### uesc_checker.sv
`timescale 1ns/100ps
module uesc_checker (
	// Watched ports
	input wire core_clk,
	input wire reset_n,
	input wire [3:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire [31:0] reg_rdata,
	input wire setup_rx,
	input wire module_enable,
	input wire frame_start_auto_enable,
	input wire bus_reset_drive,
	input wire resume_drive,
	input wire ls_eop_append,
	input wire pingpong_pointer_clear,
	input wire packet_processing_hold,
	input wire frame_start_tick
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	sequence s_ctl_wr;
		reg_wr && reg_addr == 4'h2;
	endsequence
	a_upper_zero: assert property (reg_rdata[31:8] == 24'h0)
		else $error("upper read bits set");
	a_busrst_follow: assert property (s_ctl_wr |-> ##2
		bus_reset_drive == $past(reg_wdata[4], 2)) else $error("bus reset");
	a_resume_follow: assert property (s_ctl_wr |-> ##2
		resume_drive == $past(reg_wdata[2], 2)) else $error("resume");
	a_ppclr_pulse: assert property (s_ctl_wr ##0 reg_wdata[1] |=>
		pingpong_pointer_clear) else $error("pointer clear");
	a_eop_cause: assert property (ls_eop_append |->
		$past(reg_wr && reg_addr == 4'h2 && !reg_wdata[2])) else $error("eop");
	a_hold_setup: assert property (setup_rx && module_enable |->
		##[1:2] packet_processing_hold) else $error("packet hold");
	a_sof_gate: assert property (frame_start_tick |->
		$past(frame_start_auto_enable)) else $error("frame start tick");
	a_role_excl: assert property (module_enable |->
		!frame_start_auto_enable) else $error("both roles enabled");
endmodule
bind uesc_ctrl uesc_checker u_chk (.core_clk(core_clk), .reset_n(reset_n),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rdata(reg_rdata), .setup_rx(setup_rx), .module_enable(module_enable),
	.frame_start_auto_enable(frame_start_auto_enable),
	.bus_reset_drive(bus_reset_drive), .resume_drive(resume_drive),
	.ls_eop_append(ls_eop_append),
	.pingpong_pointer_clear(pingpong_pointer_clear),
	.packet_processing_hold(packet_processing_hold),
	.frame_start_tick(frame_start_tick));

// ### uesc_far_model.sv
`timescale 1ns/100ps
module uesc_far_model (
	// Wanted line state: 0 J, 1 K, 2 single-ended zero.
	input wire [1:0] state,
	// Line pins
	output reg line_dp,
	output reg line_dm
);
	always @* begin
		line_dp = (state == 2'h0);
		line_dm = (state == 2'h1);
	end
endmodule

// ### usb_error_status_control_tb_top.sv
`timescale 1ns/100ps
module usb_error_status_control_tb_top;
	logic core_clk = 1'h0, reset_n = 1'h0, wr = 1'h0, rd = 1'h0, xv = 1'h0;
	logic [3:0] a = 4'h0;
	logic [31:0] wd = 32'h0;
	logic [7:0] ev = 8'h0;
	logic [5:0] xd = 6'h0;
	logic [2:0] st = 3'h0;
	logic [1:0] ls = 2'h0;
	wire [31:0] rdt;
	wire dp, dm, en, fs, br, rs, eop, hr, pp, hd, tk, full, irq;
	int mismatches = 0, checks_done = 0;
	initial forever #2.5 core_clk = ~core_clk;
	uesc_far_model far (.state(ls), .line_dp(dp), .line_dm(dm));
	uesc_ctrl #(.SOF_CYCLES(18'h14)) dut (
		.core_clk(core_clk), .reset_n(reset_n), .reg_addr(a),
		.reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdt),
		.line_dp(dp), .line_dm(dm), .err_events(ev), .xfer_done(xv),
		.xfer_endpoint(xd[5:2]), .xfer_tx(xd[1]), .xfer_odd(xd[0]),
		.setup_rx(st[2]), .token_start(st[1]), .token_end(st[0]),
		.module_enable(en), .frame_start_auto_enable(fs),
		.bus_reset_drive(br), .resume_drive(rs), .ls_eop_append(eop),
		.host_logic_reset(hr), .pingpong_pointer_clear(pp),
		.packet_processing_hold(hd), .frame_start_tick(tk),
		.status_fifo_full(full), .module_irq_flag(irq));
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wrr(logic [3:0] ad, logic [31:0] d);
		@(posedge core_clk);
		wr <= 1'h1;
		a <= ad;
		wd <= d;
		@(posedge core_clk);
		wr <= 1'h0;
	endtask
	task automatic rdc(logic [3:0] ad, logic [31:0] exp, string what);
		@(posedge core_clk);
		rd <= 1'h1;
		a <= ad;
		@(posedge core_clk);
		rd <= 1'h0;
		#1 chk(what, rdt, exp);
	endtask
	task automatic strobe(logic [2:0] w);
		@(posedge core_clk);
		st <= w;
		@(posedge core_clk);
		st <= 3'h0;
	endtask
	task automatic fire(logic [7:0] m);
		@(posedge core_clk);
		ev <= m;
		@(posedge core_clk);
		ev <= 8'h0;
		repeat (3) @(posedge core_clk);
	endtask
	task automatic see(logic v);
		repeat (2) @(posedge core_clk);
		#1 chk("irq", irq, v);
	endtask
	task automatic t_regs();
		rdc(4'h0, 32'h0, "enable");
		rdc(4'h1, 32'h0, "status idle");
		rdc(4'h2, 32'h80, "control");
		rdc(4'h5, 32'h0, "unmapped");
		wrr(4'h0, 32'hFFFF_FFA5);
		rdc(4'h0, 32'hA5, "enable wr");
		ls <= 2'h2;
		repeat (4) @(posedge core_clk);
		rdc(4'h2, 32'h40, "se0");
		ls <= 2'h1;
		repeat (4) @(posedge core_clk);
		rdc(4'h2, 32'h0, "k");
		ls <= 2'h0;
	endtask
	task automatic t_fifo();
		logic [5:0] q [5] = '{6'h3E, 6'h01, 6'h27, 6'h18, 6'h2B};
		for (int i = 0; i < 5; i++) begin
			@(posedge core_clk);
			xd <= q[i];
			xv <= 1'h1;
			@(posedge core_clk);
			xv <= 1'h0;
		end
		repeat (2) @(posedge core_clk);
		#1 chk("full", full, 1'h1);
		for (int i = 0; i < 4; i++) begin
			rdc(4'h1, {q[i], 2'h0}, "status");
			wrr(4'h4, 32'h1);
			repeat (2) @(posedge core_clk);
		end
		rdc(4'h1, 32'h0, "status empty");
		#1 chk("not full", full, 1'h0);
	endtask
	task automatic t_err();
		for (int k = 0; k < 8; k++) begin
			wrr(4'h0, 32'h1 << k);
			wrr(4'h4, 32'h2);
			fire(~(8'h1 << k));
			see(1'h0);
			rdc(4'h3, {24'h0, ~(8'h1 << k)}, "flags");
			fire(8'h1 << k);
			see(1'h1);
			wrr(4'h3, 32'h0);
			wrr(4'h4, 32'h0);
			see(1'h0);
			wrr(4'h4, 32'h2);
			see(1'h1);
			wrr(4'h3, 32'hFF);
			see(1'h0);
		end
	endtask
	task automatic t_ctrl();
		int n = 0;
		wrr(4'h2, 32'h1D);
		repeat (2) @(posedge core_clk);
		#1 chk("drives", {br, rs, fs, en}, 4'hE);
		repeat (45) begin
			@(posedge core_clk);
			#1 n += tk;
		end
		chk("sof", n, 2);
		strobe(3'h2);
		rdc(4'h2, 32'hBD, "busy");
		strobe(3'h1);
		rdc(4'h2, 32'h9D, "idle");
		// One millisecond is scaled to 20 cycles, as for the frame timer.
		n = 0;
		repeat (500) begin
			@(posedge core_clk);
			#1 n += rs;
		end
		chk("resume held", n, 500);
		wrr(4'h2, 32'h19);
		#1 chk("eop", eop, 1'h1);
		wrr(4'h2, 32'h01);
		n = 0;
		repeat (3) begin
			#1 n += hr;
			@(posedge core_clk);
		end
		chk("host rst", n, 1);
		rdc(4'h2, 32'h81, "device");
		chk("drives dev", {br, rs, fs, en}, 4'h1);
		strobe(3'h4);
		rdc(4'h2, 32'hA1, "hold");
		chk("hold out", hd, 1'h1);
		wrr(4'h2, 32'h03);
		#1 chk("ppclr", pp, 1'h1);
		rdc(4'h2, 32'h81, "released");
		chk("hold out", hd, 1'h0);
	endtask
	initial begin
		repeat (20000) @(posedge core_clk);
		mismatches++;
		end_sim();
	end
	initial begin
		repeat (12) @(posedge core_clk);
		reset_n <= 1'h1;
		t_regs();
		t_fifo();
		t_err();
		t_ctrl();
		end_sim();
	end
endmodule
